// ---- prog_port_pkg.sv ----
/*
   Constants shared by the parallel programming port: pin codings, command
   bytes, page geometry, reset values of the fuse and lock bytes, timing.
   Assumes a 250 MHz core clock; the entry guard and start wait times are converted to its cycles.
*/
package prog_port_pkg;

   localparam int CLK_PERIOD_NS = 4;
   localparam int PULSE_MIN_NS = 250;
   localparam int ENTRY_GUARD_NS = 100;
   localparam int ENTRY_GUARD_CYC = (ENTRY_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int START_WAIT_NS = 50000;
   localparam int START_WAIT_CYC = (START_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam logic [1:0] ACT_LOAD_ADDR = 2'h0;
   localparam logic [1:0] ACT_LOAD_DATA = 2'h1;
   localparam logic [1:0] ACT_LOAD_CMD = 2'h2;
   localparam logic [1:0] ACT_IDLE = 2'h3;

   localparam logic [7:0] CMD_NOP = 8'h00;
   localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
   localparam logic [7:0] CMD_WRITE_FUSE = 8'h40;
   localparam logic [7:0] CMD_WRITE_LOCK = 8'h20;
   localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;
   localparam logic [7:0] CMD_WRITE_EEPROM = 8'h11;
   localparam logic [7:0] CMD_READ_SIG = 8'h08;
   localparam logic [7:0] CMD_READ_FUSE_LOCK = 8'h04;
   localparam logic [7:0] CMD_READ_FLASH = 8'h02;
   localparam logic [7:0] CMD_READ_EEPROM = 8'h03;

   localparam logic [3:0] ENTRY_PATTERN = 4'h0;

   localparam logic [1:0] NVM_WRITE_FLASH = 2'h0;
   localparam logic [1:0] NVM_WRITE_EEPROM = 2'h1;
   localparam logic [1:0] NVM_ERASE_FLASH = 2'h2;
   localparam logic [1:0] NVM_ERASE_EEPROM = 2'h3;

   localparam int FLASH_PAGE_WORDS = 64;
   localparam int EEPROM_PAGE_BYTES = 4;

   // {byte_select_two, byte_select_one} while reading fuse and lock bytes
   localparam logic [1:0] SEL_FUSE_LOW = 2'h0;
   localparam logic [1:0] SEL_LOCK = 2'h1;
   localparam logic [1:0] SEL_FUSE_EXT = 2'h2;
   localparam logic [1:0] SEL_FUSE_HIGH = 2'h3;

   localparam logic [7:0] FUSE_LOW_RST = 8'h62;
   localparam logic [7:0] FUSE_HIGH_RST = 8'hDF;
   localparam logic [7:0] FUSE_EXT_RST = 8'hFF;
   localparam logic [7:0] LOCK_ERASED = 8'hFF;
   localparam logic [7:0] BYTE_ERASED = 8'hFF;
   localparam int KEEP_FUSE_BIT = 3;

   localparam logic [1:0] SIG_ADDR_0 = 2'h0;
   localparam logic [1:0] SIG_ADDR_1 = 2'h1;
   localparam logic [1:0] SIG_ADDR_2 = 2'h2;

endpackage

// ---- pin_sync.sv ----
/*
   Two-flop synchroniser for a group of pins.
   Assumes each bit is an independent level; no bus coherence is promised.
*/
`timescale 1ns/10ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic ref_clk_in,
   input wire logic srst_in,
   input wire logic [WIDTH-1:0] pins_in,
   output logic [WIDTH-1:0] pins_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] stable_q;

   always_ff @(posedge ref_clk_in)
   begin
      if (srst_in)
      begin
         meta_q <= '0;
         stable_q <= '0;
      end
      else
      begin
         meta_q <= pins_in;
         stable_q <= meta_q;
      end
   end

   assign pins_out = stable_q;

endmodule

// ---- parallel_program_port.sv ----
/*
   Parallel programming port: entry sequence, command/address/data loading,
   page buffer, chip erase, page programming and read-back multiplexing.
   Assumes the nonvolatile arrays sit behind a req/ack port on ref_clk_in,
   and that all programmer pins are asynchronous to ref_clk_in.
*/
`timescale 1ns/10ps
module parallel_program_port #(
   parameter int STARTUP_CYC = prog_port_pkg::START_WAIT_CYC,
   parameter int PAGE_WORDS = prog_port_pkg::FLASH_PAGE_WORDS,
   parameter int EE_PAGE_BYTES = prog_port_pkg::EEPROM_PAGE_BYTES,
   parameter logic [7:0] SIG_BYTE0 = 8'h5A,
   parameter logic [7:0] SIG_BYTE1 = 8'h3C,
   parameter logic [7:0] SIG_BYTE2 = 8'h96,
   parameter logic [7:0] CAL_BYTE = 8'h80
) (
   input wire logic ref_clk_in,
   input wire logic srst_in,
   input wire logic prog_voltage_in,
   input wire logic load_clock_pin_in,
   input wire logic action_sel0_in,
   input wire logic action_sel1_in,
   input wire logic page_latch_in,
   input wire logic write_n_in,
   input wire logic output_enable_n_in,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe_out,
   output logic ready_busy_out,
   output logic prog_mode_out,
   output logic nvm_req_out,
   output logic [1:0] nvm_op_out,
   output logic [15:0] nvm_addr_out,
   output logic [15:0] nvm_wdata_out,
   output logic nvm_rd_eeprom_out,
   input wire logic nvm_ack_in,
   input wire logic [15:0] nvm_rdata_in
);

   localparam int IDX_W = $clog2(PAGE_WORDS);
   localparam int GUARD_W = $clog2(prog_port_pkg::ENTRY_GUARD_CYC + 1);
   localparam int START_W = $clog2(STARTUP_CYC + 1);
   localparam logic [GUARD_W-1:0] GUARD_LAST = GUARD_W'(prog_port_pkg::ENTRY_GUARD_CYC - 1);
   localparam logic [START_W-1:0] START_LAST = START_W'(STARTUP_CYC - 1);
   localparam logic [IDX_W:0] FLASH_LEN = (IDX_W + 1)'(PAGE_WORDS);
   localparam logic [IDX_W:0] EE_LEN = (IDX_W + 1)'(EE_PAGE_BYTES);

   typedef enum logic [3:0] {
      ST_OFF,
      ST_GUARD,
      ST_FAIL,
      ST_START,
      ST_IDLE,
      ST_ERASE_FLASH,
      ST_ERASE_EEPROM,
      ST_ERASE_LOCK,
      ST_PAGE,
      ST_REG_WRITE
   } port_state_e;

   logic [6:0] ctrl_s;
   logic [7:0] data_s;
   logic volt_s;
   logic load_clk_s;
   logic act0_s;
   logic act1_s;
   logic latch_s;
   logic wr_n_s;
   logic oe_n_s;
   logic byte_select_one;
   logic byte_select_two;
   logic [1:0] action;
   logic [3:0] entry_pins;
   logic volt_q;
   logic load_clk_q;
   logic latch_q;
   logic wr_n_q;
   logic load_rise;
   logic latch_rise;
   logic wr_fall;
   port_state_e state_q;
   logic [GUARD_W-1:0] guard_cnt_q;
   logic [START_W-1:0] start_cnt_q;
   logic [IDX_W-1:0] idx_q;
   logic [IDX_W:0] len_q;
   logic page_eeprom_q;
   logic [7:0] cmd_q;
   logic [7:0] addr_lo_q;
   logic [7:0] addr_hi_q;
   logic [7:0] data_lo_q;
   logic [7:0] data_hi_q;
   logic page_dirty_q;
   logic [15:0] page_mem [PAGE_WORDS];
   logic [7:0] fuse_low_q;
   logic [7:0] fuse_high_q;
   logic [7:0] fuse_ext_q;
   logic [7:0] lock_q;
   logic idle;
   logic keep_eeprom;
   logic [15:0] addr_full;
   logic [15:0] page_base;
   logic [IDX_W-1:0] latch_idx;
   logic [7:0] read_byte;

   pin_sync #(
      .WIDTH(7)
   ) u_ctrl_sync (
      .ref_clk_in(ref_clk_in),
      .srst_in(srst_in),
      .pins_in({prog_voltage_in, load_clock_pin_in, action_sel0_in, action_sel1_in,
                page_latch_in, write_n_in, output_enable_n_in}),
      .pins_out(ctrl_s)
   );

   pin_sync #(
      .WIDTH(8)
   ) u_data_sync (
      .ref_clk_in(ref_clk_in),
      .srst_in(srst_in),
      .pins_in(data_in),
      .pins_out(data_s)
   );

   assign {volt_s, load_clk_s, act0_s, act1_s, latch_s, wr_n_s, oe_n_s} = ctrl_s;
   // shared pins: the byte selects ride on the action and latch pins
   assign byte_select_one = latch_s;
   assign byte_select_two = act1_s;
   assign action = {act1_s, act0_s};
   assign entry_pins = {latch_s, act1_s, act0_s, wr_n_s};

   always_ff @(posedge ref_clk_in)
   begin
      if (srst_in)
      begin
         volt_q <= 1'b0;
         load_clk_q <= 1'b0;
         latch_q <= 1'b0;
         wr_n_q <= 1'b0; // same as the sync reset, so no false fall
      end
      else
      begin
         volt_q <= volt_s;
         load_clk_q <= load_clk_s;
         latch_q <= latch_s;
         wr_n_q <= wr_n_s;
      end
   end

   assign load_rise = load_clk_s & ~load_clk_q;
   assign latch_rise = latch_s & ~latch_q;
   assign wr_fall = ~wr_n_s & wr_n_q;

   assign idle = (state_q == ST_IDLE);
   assign ready_busy_out = idle;
   assign prog_mode_out = !(state_q inside {ST_OFF, ST_GUARD, ST_FAIL});
   // fuse acts at once from fuse_high_q; the other fuses are only read back
   assign keep_eeprom = ~fuse_high_q[prog_port_pkg::KEEP_FUSE_BIT];
   assign addr_full = {addr_hi_q, addr_lo_q};
   assign page_base = addr_full & ~(16'(len_q) - 16'h0001);
   assign latch_idx = (cmd_q == prog_port_pkg::CMD_WRITE_EEPROM) ?
                      (addr_lo_q[IDX_W-1:0] & IDX_W'(EE_PAGE_BYTES - 1)) :
                      (addr_lo_q[IDX_W-1:0] & IDX_W'(PAGE_WORDS - 1));

   // entry, mode and operation sequencing
   always_ff @(posedge ref_clk_in)
   begin
      if (srst_in)
      begin
         state_q <= ST_OFF;
         guard_cnt_q <= '0;
         start_cnt_q <= '0;
      end
      else if (!volt_s)
      begin
         state_q <= ST_OFF;
      end
      else
      begin
         case (state_q)
            ST_OFF:
            begin
               guard_cnt_q <= '0;
               if (!volt_q)
               begin
                  state_q <= (entry_pins == prog_port_pkg::ENTRY_PATTERN) ? ST_GUARD : ST_FAIL;
               end
            end
            ST_GUARD:
            begin
               if (entry_pins != prog_port_pkg::ENTRY_PATTERN)
               begin
                  state_q <= ST_FAIL;
               end
               else if (guard_cnt_q == GUARD_LAST)
               begin
                  state_q <= ST_START;
                  start_cnt_q <= '0;
               end
               else
               begin
                  guard_cnt_q <= guard_cnt_q + 1'b1;
               end
            end
            ST_FAIL:
            begin
               state_q <= ST_FAIL; // held until the high voltage goes away
            end
            ST_START:
            begin
               if (start_cnt_q == START_LAST)
               begin
                  state_q <= ST_IDLE;
               end
               else
               begin
                  start_cnt_q <= start_cnt_q + 1'b1;
               end
            end
            ST_IDLE:
            begin
               if (wr_fall)
               begin
                  if (cmd_q == prog_port_pkg::CMD_CHIP_ERASE)
                  begin
                     state_q <= ST_ERASE_FLASH;
                  end
                  else if ((cmd_q == prog_port_pkg::CMD_WRITE_FLASH ||
                            cmd_q == prog_port_pkg::CMD_WRITE_EEPROM) && page_dirty_q)
                  begin
                     state_q <= ST_PAGE;
                  end
                  else if (cmd_q == prog_port_pkg::CMD_WRITE_FUSE ||
                           cmd_q == prog_port_pkg::CMD_WRITE_LOCK)
                  begin
                     state_q <= ST_REG_WRITE;
                  end
               end
            end
            ST_ERASE_FLASH:
            begin
               if (nvm_req_out && nvm_ack_in)
               begin
                  state_q <= keep_eeprom ? ST_ERASE_LOCK : ST_ERASE_EEPROM;
               end
            end
            ST_ERASE_EEPROM:
            begin
               if (nvm_req_out && nvm_ack_in)
               begin
                  state_q <= ST_ERASE_LOCK;
               end
            end
            ST_PAGE:
            begin
               if (nvm_req_out && nvm_ack_in && 32'(idx_q) == 32'(len_q) - 1)
               begin
                  state_q <= ST_IDLE;
               end
            end
            default:
            begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // request side of the nonvolatile array port
   always_ff @(posedge ref_clk_in)
   begin
      if (srst_in)
      begin
         nvm_req_out <= 1'b0;
         nvm_op_out <= prog_port_pkg::NVM_WRITE_FLASH;
         nvm_addr_out <= '0;
         nvm_wdata_out <= '0;
         idx_q <= '0;
         len_q <= FLASH_LEN;
         page_eeprom_q <= 1'b0;
      end
      else if (state_q == ST_ERASE_FLASH || state_q == ST_ERASE_EEPROM)
      begin
         nvm_op_out <= (state_q == ST_ERASE_FLASH) ? prog_port_pkg::NVM_ERASE_FLASH :
                                                     prog_port_pkg::NVM_ERASE_EEPROM;
         // drop on ack, so one request per step
         nvm_req_out <= !(nvm_req_out && nvm_ack_in);
      end
      else if (state_q == ST_PAGE)
      begin
         if (!nvm_req_out)
         begin
            nvm_req_out <= 1'b1;
            nvm_op_out <= page_eeprom_q ? prog_port_pkg::NVM_WRITE_EEPROM :
                                          prog_port_pkg::NVM_WRITE_FLASH;
            nvm_addr_out <= page_base | 16'(idx_q);
            nvm_wdata_out <= page_mem[idx_q];
         end
         else if (nvm_ack_in)
         begin
            nvm_req_out <= 1'b0;
            idx_q <= idx_q + 1'b1;
         end
      end
      else
      begin
         nvm_req_out <= 1'b0;
         nvm_addr_out <= addr_full; // read address follows the loaded address
         idx_q <= '0;
         page_eeprom_q <= (cmd_q == prog_port_pkg::CMD_WRITE_EEPROM);
         len_q <= (cmd_q == prog_port_pkg::CMD_WRITE_EEPROM) ? EE_LEN : FLASH_LEN;
      end
   end

   assign nvm_rd_eeprom_out = (cmd_q == prog_port_pkg::CMD_READ_EEPROM);

   // command, address and data loading; only while ready
   always_ff @(posedge ref_clk_in)
   begin
      if (srst_in || state_q == ST_OFF)
      begin
         cmd_q <= prog_port_pkg::CMD_NOP;
         addr_lo_q <= '0;
         addr_hi_q <= '0;
         data_lo_q <= prog_port_pkg::BYTE_ERASED;
         data_hi_q <= prog_port_pkg::BYTE_ERASED;
      end
      else if (idle && load_rise)
      begin
         case (action)
            prog_port_pkg::ACT_LOAD_ADDR:
            begin
               if (byte_select_one)
               begin
                  addr_hi_q <= data_s;
               end
               else
               begin
                  addr_lo_q <= data_s;
               end
            end
            prog_port_pkg::ACT_LOAD_DATA:
            begin
               if (byte_select_one)
               begin
                  data_hi_q <= data_s;
               end
               else
               begin
                  data_lo_q <= data_s;
               end
            end
            prog_port_pkg::ACT_LOAD_CMD:
            begin
               cmd_q <= data_s;
               if (data_s == prog_port_pkg::CMD_NOP)
               begin
                  data_lo_q <= prog_port_pkg::BYTE_ERASED;
                  data_hi_q <= prog_port_pkg::BYTE_ERASED;
               end
            end
            default: ;
         endcase
      end
   end

   // page buffer collects words until the page is programmed
   always_ff @(posedge ref_clk_in)
   begin
      if (idle && latch_rise)
      begin
         page_mem[latch_idx] <= {data_hi_q, data_lo_q};
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (srst_in || state_q == ST_OFF)
      begin
         page_dirty_q <= 1'b0;
      end
      else if (idle && latch_rise)
      begin
         page_dirty_q <= 1'b1;
      end
      else if ((idle && load_rise && action == prog_port_pkg::ACT_LOAD_CMD &&
                data_s == prog_port_pkg::CMD_NOP) || state_q == ST_PAGE)
      begin
         page_dirty_q <= 1'b0;
      end
   end

   // fuse and lock bytes; erased lock only after the arrays are done
   always_ff @(posedge ref_clk_in)
   begin
      if (srst_in)
      begin
         fuse_low_q <= prog_port_pkg::FUSE_LOW_RST;
         fuse_high_q <= prog_port_pkg::FUSE_HIGH_RST;
         fuse_ext_q <= prog_port_pkg::FUSE_EXT_RST;
         lock_q <= prog_port_pkg::LOCK_ERASED;
      end
      else if (state_q == ST_ERASE_LOCK)
      begin
         lock_q <= prog_port_pkg::LOCK_ERASED;
      end
      else if (state_q == ST_REG_WRITE && cmd_q == prog_port_pkg::CMD_WRITE_LOCK)
      begin
         lock_q <= lock_q & data_lo_q; // only chip erase or srst_in returns bits to one
      end
      else if (state_q == ST_REG_WRITE && cmd_q == prog_port_pkg::CMD_WRITE_FUSE)
      begin
         if (byte_select_two)
         begin
            fuse_ext_q <= data_lo_q;
         end
         else if (byte_select_one)
         begin
            fuse_high_q <= data_lo_q;
         end
         else
         begin
            fuse_low_q <= data_lo_q;
         end
      end
   end

   always_comb
   begin
      read_byte = prog_port_pkg::BYTE_ERASED;
      if (cmd_q == prog_port_pkg::CMD_READ_FLASH)
      begin
         read_byte = byte_select_one ? nvm_rdata_in[15:8] : nvm_rdata_in[7:0];
      end
      else if (cmd_q == prog_port_pkg::CMD_READ_EEPROM)
      begin
         read_byte = nvm_rdata_in[7:0];
      end
      else if (cmd_q == prog_port_pkg::CMD_READ_SIG)
      begin
         if (byte_select_one)
         begin
            read_byte = CAL_BYTE;
         end
         else if (addr_lo_q[1:0] == prog_port_pkg::SIG_ADDR_0)
         begin
            read_byte = SIG_BYTE0;
         end
         else if (addr_lo_q[1:0] == prog_port_pkg::SIG_ADDR_1)
         begin
            read_byte = SIG_BYTE1;
         end
         else if (addr_lo_q[1:0] == prog_port_pkg::SIG_ADDR_2)
         begin
            read_byte = SIG_BYTE2;
         end
      end
      else if (cmd_q == prog_port_pkg::CMD_READ_FUSE_LOCK)
      begin
         case ({byte_select_two, byte_select_one})
            prog_port_pkg::SEL_FUSE_LOW: read_byte = fuse_low_q;
            prog_port_pkg::SEL_LOCK: read_byte = lock_q;
            prog_port_pkg::SEL_FUSE_EXT: read_byte = fuse_ext_q;
            default: read_byte = fuse_high_q;
         endcase
      end
   end

   // bus driven only in programming mode with output enable low
   always_ff @(posedge ref_clk_in)
   begin
      if (srst_in)
      begin
         data_out <= '0;
         data_oe_out <= 1'b0;
      end
      else
      begin
         data_oe_out <= prog_mode_out && volt_s && !oe_n_s;
         data_out <= read_byte;
      end
   end

endmodule

// ---- prog_port_properties.sv ----
/*
   Port-level properties of parallel_program_port.
   Assumes one clock domain, ref_clk_in, with synchronous reset srst_in.
*/
`timescale 1ns/10ps
module prog_port_properties (
   input wire logic ref_clk_in,
   input wire logic srst_in,
   input wire logic prog_voltage_in,
   input wire logic output_enable_n_in,
   input wire logic data_oe_out,
   input wire logic ready_busy_out,
   input wire logic prog_mode_out,
   input wire logic nvm_req_out,
   input wire logic [1:0] nvm_op_out,
   input wire logic [15:0] nvm_addr_out,
   input wire logic nvm_ack_in
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (srst_in);
   a_oe_needs_mode: assert property (data_oe_out |-> prog_mode_out)
      else $error("data bus driven outside programming mode");
   a_oe_follows_pin: assert property ((prog_mode_out && !output_enable_n_in) [*4] |=> data_oe_out)
      else $error("data bus not driven under output enable");
   a_oe_released: assert property (output_enable_n_in [*4] |=> !data_oe_out)
      else $error("data bus driven without output enable");
   a_ready_in_mode: assert property (!prog_mode_out |-> !ready_busy_out)
      else $error("ready outside programming mode");
   a_busy_on_req: assert property (nvm_req_out |-> !ready_busy_out)
      else $error("ready while array request open");
   a_req_held: assert property (nvm_req_out && !nvm_ack_in |=> nvm_req_out && $stable(nvm_op_out)
      && $stable(nvm_addr_out))
      else $error("array request changed before ack");
   a_ack_ends_req: assert property (nvm_ack_in |=> !nvm_req_out)
      else $error("array request held after ack");
   a_mode_drops: assert property (!prog_voltage_in [*4] |=> !prog_mode_out)
      else $error("programming mode kept without voltage");
endmodule

// ---- programmer_model.sv ----
/*
   Model of the external programmer driving the port's pins.
   Assumes ref_clk_in is the core clock; pins change on its falling edge.
*/
`timescale 1ns/10ps
module programmer_model (
   input wire logic ref_clk_in,
   output logic prog_voltage_out,
   output logic load_clock_out,
   output logic action_sel0_out,
   output logic action_sel1_out,
   output logic page_latch_out,
   output logic write_n_out,
   output logic output_enable_n_out,
   output logic [7:0] data_out
);
   localparam int HOLD = 64; // 256 ns, above the pulse minimum
   initial
   begin
      {prog_voltage_out, load_clock_out, action_sel0_out, action_sel1_out} = 4'h0;
      {page_latch_out, write_n_out, output_enable_n_out} = 3'h3;
      data_out = 8'h00;
   end
   task automatic gap(input int n);
      repeat (n) @(negedge ref_clk_in);
   endtask
   task automatic enter(input logic glitch);
      prog_voltage_out = 1'b0;
      {page_latch_out, action_sel1_out, action_sel0_out, write_n_out} = 4'h0;
      repeat (6)
      begin
         load_clock_out = 1'b1;
         gap(4);
         load_clock_out = 1'b0;
         gap(4);
      end
      gap(32);
      prog_voltage_out = 1'b1;
      if (glitch)
      begin
         gap(4);
         action_sel0_out = 1'b1;
      end
      gap(HOLD);
      write_n_out = 1'b1;
      action_sel0_out = 1'b0;
   endtask
   task automatic load(input logic [1:0] act, input logic bs1, input logic [7:0] val);
      {action_sel1_out, action_sel0_out} = act;
      page_latch_out = bs1;
      data_out = val;
      gap(HOLD);
      load_clock_out = 1'b1;
      gap(HOLD);
      load_clock_out = 1'b0;
      data_out = ~val;
      gap(HOLD);
   endtask
   task automatic pulse_wr();
      write_n_out = 1'b0;
      gap(HOLD);
      write_n_out = 1'b1;
      gap(HOLD);
   endtask
   task automatic latch();
      page_latch_out = 1'b0;
      gap(HOLD);
      page_latch_out = 1'b1;
      gap(HOLD);
      page_latch_out = 1'b0;
      gap(HOLD);
   endtask
   task automatic oe(input logic on, input logic bs2, input logic bs1);
      action_sel1_out = bs2;
      page_latch_out = bs1;
      output_enable_n_out = !on;
      gap(8);
   endtask
endmodule

// ---- parallel_program_port_tb.sv ----
/*
   Self-checking bench for parallel_program_port.
   Assumes programmer_model on the pins and a prompt array responder here.
*/
`timescale 1ns/10ps
module parallel_program_port_tb;
   localparam logic [31:0] SIGS = 32'hA1B2C3D4; // arbitrary identity values
   logic ref_clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic vpp, lclk, as0, as1, plat, wr_n, oe_n, doe, rdy, pmode, req, rde;
   logic ack = 1'b0;
   logic [7:0] pdata, dbus, dout;
   logic [1:0] op;
   logic [15:0] addr, wdata, rdata, wlog;
   logic [1:0] ops[$];
   int error_cnt = 0;
   int checks_done = 0;
   always #2 ref_clk_in = ~ref_clk_in;
   assign dbus = doe ? dout : pdata;
   assign rdata = {addr[7:0], addr[15:8]};
   programmer_model pgm (.ref_clk_in(ref_clk_in), .prog_voltage_out(vpp),
      .load_clock_out(lclk), .action_sel0_out(as0), .action_sel1_out(as1),
      .page_latch_out(plat), .write_n_out(wr_n), .output_enable_n_out(oe_n), .data_out(pdata));
   parallel_program_port #(.STARTUP_CYC(200), .SIG_BYTE0(SIGS[31:24]), .SIG_BYTE1(SIGS[23:16]),
      .SIG_BYTE2(SIGS[15:8]), .CAL_BYTE(SIGS[7:0])) DUT (.ref_clk_in(ref_clk_in),
      .srst_in(srst_in), .prog_voltage_in(vpp), .load_clock_pin_in(lclk),
      .action_sel0_in(as0), .action_sel1_in(as1), .page_latch_in(plat), .write_n_in(wr_n),
      .output_enable_n_in(oe_n), .data_in(dbus), .data_out(dout), .data_oe_out(doe),
      .ready_busy_out(rdy), .prog_mode_out(pmode), .nvm_req_out(req), .nvm_op_out(op),
      .nvm_addr_out(addr), .nvm_wdata_out(wdata), .nvm_rd_eeprom_out(rde),
      .nvm_ack_in(ack), .nvm_rdata_in(rdata));
   always @(posedge ref_clk_in)
   begin
      ack <= req && !ack;
      if (req && ack)
      begin
         ops.push_back(op);
         if (op == 2'h0 && addr == 16'h1205)
            wlog <= wdata;
      end
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_rdy();
      int n;
      n = 0;
      while (rdy !== 1'b1 && n < 5000)
      begin
         @(negedge ref_clk_in);
         n++;
      end
      if (n == 5000)
      begin
         error_cnt++;
         $display("[FAIL] %0t ready wait ran out", $time);
         finish_test();
      end
   endtask
   task automatic rd(input logic bs2, input logic bs1, input logic [7:0] exp);
      pgm.oe(1'b1, bs2, bs1);
      chk({8'h00, dbus}, {8'h00, exp});
      pgm.oe(1'b0, bs2, bs1);
      chk({15'h0000, doe}, 16'h0000);
   endtask
   task automatic t_entry();
      pgm.enter(1'b1);
      pgm.gap(100);
      chk({15'h0000, pmode}, 16'h0000);
      pgm.enter(1'b0);
      chk({15'h0000, rdy}, 16'h0000);
      wait_rdy();
      chk({15'h0000, pmode}, 16'h0001);
      pgm.gap(20);
      $display("entry test done");
   endtask
   task automatic t_ident();
      pgm.load(2'h2, 1'b0, prog_port_pkg::CMD_READ_SIG);
      for (int i = 0; i < 3; i++)
      begin
         pgm.load(2'h0, 1'b0, 8'(i));
         rd(1'b0, 1'b0, SIGS[31-8*i -: 8]);
      end
      pgm.load(2'h0, 1'b0, 8'h00);
      rd(1'b0, 1'b1, SIGS[7:0]);
      pgm.load(2'h2, 1'b0, prog_port_pkg::CMD_READ_FUSE_LOCK);
      rd(1'b0, 1'b0, prog_port_pkg::FUSE_LOW_RST);
      rd(1'b1, 1'b1, prog_port_pkg::FUSE_HIGH_RST);
      rd(1'b1, 1'b0, prog_port_pkg::FUSE_EXT_RST);
      $display("ident test done");
   endtask
   task automatic t_erase();
      pgm.load(2'h2, 1'b0, prog_port_pkg::CMD_WRITE_LOCK);
      pgm.load(2'h1, 1'b0, 8'hFC);
      pgm.pulse_wr();
      wait_rdy();
      pgm.load(2'h2, 1'b0, prog_port_pkg::CMD_READ_FUSE_LOCK);
      rd(1'b0, 1'b1, 8'hFC);
      pgm.load(2'h2, 1'b0, prog_port_pkg::CMD_CHIP_ERASE);
      ops.delete();
      pgm.pulse_wr();
      wait_rdy();
      chk(16'(ops.size()), 16'h0002);
      chk({14'h0000, ops[0]}, 16'h0002);
      chk({14'h0000, ops[1]}, 16'h0003);
      pgm.load(2'h2, 1'b0, prog_port_pkg::CMD_READ_FUSE_LOCK);
      rd(1'b0, 1'b1, prog_port_pkg::LOCK_ERASED);
      rd(1'b1, 1'b1, prog_port_pkg::FUSE_HIGH_RST);
      pgm.load(2'h2, 1'b0, prog_port_pkg::CMD_WRITE_FUSE);
      pgm.load(2'h1, 1'b0, 8'hD7);
      pgm.oe(1'b0, 1'b0, 1'b1);
      pgm.pulse_wr();
      wait_rdy();
      pgm.load(2'h2, 1'b0, prog_port_pkg::CMD_CHIP_ERASE);
      ops.delete();
      pgm.pulse_wr();
      wait_rdy();
      chk(16'(ops.size()), 16'h0001);
      $display("erase test done");
   endtask
   task automatic t_page();
      pgm.load(2'h2, 1'b0, prog_port_pkg::CMD_WRITE_FLASH);
      pgm.load(2'h0, 1'b0, 8'h05);
      pgm.load(2'h0, 1'b1, 8'h12);
      pgm.load(2'h1, 1'b0, 8'h34);
      pgm.load(2'h1, 1'b1, 8'h56);
      pgm.load(2'h3, 1'b0, 8'hEE);
      pgm.latch();
      ops.delete();
      pgm.pulse_wr();
      chk({15'h0000, rdy}, 16'h0000);
      wait_rdy();
      chk(16'(ops.size()), 16'h0040);
      chk(wlog, 16'h5634);
      pgm.latch();
      pgm.load(2'h2, 1'b0, prog_port_pkg::CMD_NOP);
      pgm.load(2'h2, 1'b0, prog_port_pkg::CMD_WRITE_FLASH);
      ops.delete();
      pgm.pulse_wr();
      chk(16'(ops.size()), 16'h0000);
      pgm.load(2'h2, 1'b0, prog_port_pkg::CMD_READ_FLASH);
      rd(1'b0, 1'b0, 8'h12);
      rd(1'b0, 1'b1, 8'h05);
      pgm.load(2'h2, 1'b0, prog_port_pkg::CMD_READ_EEPROM);
      chk({15'h0000, rde}, 16'h0001);
      $display("page test done");
   endtask
   initial
   begin
      repeat (8) @(negedge ref_clk_in);
      srst_in = 1'b0;
      t_entry();
      t_ident();
      t_erase();
      t_page();
      finish_test();
   end
endmodule
bind parallel_program_port prog_port_properties chk_i (.ref_clk_in(ref_clk_in),
   .srst_in(srst_in), .prog_voltage_in(prog_voltage_in),
   .output_enable_n_in(output_enable_n_in), .data_oe_out(data_oe_out),
   .ready_busy_out(ready_busy_out), .prog_mode_out(prog_mode_out),
   .nvm_req_out(nvm_req_out), .nvm_op_out(nvm_op_out), .nvm_addr_out(nvm_addr_out),
   .nvm_ack_in(nvm_ack_in));
